// [bprms_pkg.sv]
// Package with the register map, field layout and types of the backplane rate and memory self-test registers.
package bprms_pkg;
  localparam int unsigned ADDR_W = 14;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned NUM_STREAMS = 32;
  localparam int unsigned WIDE_STREAMS = 16;
  localparam logic [13:0] IN_RATE_BASE = 14'h010D;
  localparam logic [13:0] OUT_RATE_BASE = 14'h012D;
  localparam logic [13:0] SELFTEST_ADDR = 14'h014D;
  localparam logic [13:0] REVISION_ADDR = 14'h3FFF;
  localparam int unsigned RATE_W = 2;
  localparam int unsigned REV_W = 4;
  localparam logic [1:0] RATE_RESET = 2'h0;
  localparam logic [15:0] SELFTEST_RESET = 16'h0000;
  localparam logic [15:0] SELFTEST_ENABLE_VALUE = 16'h1000;
  localparam int unsigned BIT_MODE_EN = 12;
  localparam int unsigned BIT_START_BPD = 11;
  localparam int unsigned BIT_DONE_BPD = 10;
  localparam int unsigned BIT_PASS_BPD = 9;
  localparam int unsigned BIT_START_LD = 8;
  localparam int unsigned BIT_DONE_LD = 7;
  localparam int unsigned BIT_PASS_LD = 6;
  localparam int unsigned BIT_START_BPC = 5;
  localparam int unsigned BIT_DONE_BPC = 4;
  localparam int unsigned BIT_PASS_BPC = 3;
  localparam int unsigned BIT_START_LC = 2;
  localparam int unsigned BIT_DONE_LC = 1;
  localparam int unsigned BIT_PASS_LC = 0;
  localparam int unsigned NUM_MEMS = 4;
  localparam int unsigned TEST_CYCLES = 64;
  typedef enum logic [2:0] {
    BPRMS_RATE_2M = 3'h0,
    BPRMS_RATE_4M = 3'h1,
    BPRMS_RATE_8M = 3'h2,
    BPRMS_RATE_16M = 3'h3,
    BPRMS_RATE_32M = 3'h4
  } bprms_rate_t;
  typedef struct packed {
    logic wr;
    logic rd;
    logic [13:0] addr;
    logic [15:0] wdata;
  } bprms_req_t;
  typedef struct packed {
    logic start;
    logic done;
    logic pass;
  } bprms_test_t;
endpackage

// [bprms_mem_test.sv]
// One memory self-test sequencer with start pulse, completion flag and pass result.
`timescale 1ns/1ps
module bprms_mem_test #(
  parameter int unsigned CYCLES = bprms_pkg::TEST_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire logic i_start,
  input wire logic i_mode_en,
  input wire logic i_fail,
  output logic o_done,
  output logic o_pass
);
  import bprms_pkg::*;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } bprms_st_t;
  bprms_st_t state_q;
  bprms_st_t state_d;
  logic [$clog2(CYCLES+1)-1:0] cnt_q;
  logic fail_q;
  wire last_w = (cnt_q == ($clog2(CYCLES+1))'(CYCLES - 1));
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (i_start && i_mode_en) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!i_mode_en) begin
          state_d = ST_IDLE;
        end else if (last_w) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (i_start && i_mode_en) begin
          state_d = ST_RUN;
        end else if (!i_mode_en) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      fail_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q != ST_RUN) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
      if (state_d == ST_RUN && state_q != ST_RUN) begin
        fail_q <= 1'b0;
      end else if (state_q == ST_RUN && i_fail) begin
        fail_q <= 1'b1;
      end
    end
  end
  // Completion rises when the sequence finishes; the result is held with it.
  assign o_done = (state_q == ST_DONE); // see R11
  assign o_pass = (state_q == ST_DONE) && !fail_q; // see R12 see R16
endmodule

// [bprms_regs.sv]
// Backplane stream rate registers, memory self-test register and silicon revision register.
// Overview of operation
// R01: Thirty-two input rate registers from 010Dh, two-bit rate in bits 1-0.
// R02: Input rate codes 00,01,10,11 give 2, 4, 8, 16 Mb/s.
// R03: Thirty-two output rate registers from 012Dh, two-bit rate in bits 1-0.
// R04: Output rate codes 00,01,10,11 give 2, 4, 8, 16 Mb/s.
// R05: Wide mode ignores rate registers; streams 0-15 at 32 Mb/s, 16-31 unused.
// R06: Self-test starts by writing 1000h, then bit 12 plus start bits.
// R07: Bit 12 high selects self-test mode, low selects scan mode.
// R08: A start bit launches its test only on a rising transition.
// R09: Bit 11 starts backplane data test, bit 8 local data test.
// R10: Bit 5 starts backplane connection test, bit 2 local connection test.
// R11: Done flags at bits 10, 7, 4, 1 rise when each test finishes.
// R12: Pass flags at bits 9, 6, 3, 0 read high for pass, low fail.
// R13: Revision register at 3FFFh shows four-bit revision in bits 3-0.
// R14: Writes to the revision register have no effect.
// R15: Reserved bits read zero; writes to them and status flags are ignored.
// R16: A pass flag is meaningful only while its done flag is high.
`timescale 1ns/1ps
module bprms_regs #(
  parameter logic [3:0] REVISION = 4'h1, // Revision value is arbitrary.
  parameter int unsigned TEST_LEN = bprms_pkg::TEST_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire bprms_pkg::bprms_req_t i_req,
  input wire logic i_wide_mode,
  input wire logic [3:0] i_mem_fail,
  output logic [15:0] o_rdata,
  output bprms_pkg::bprms_rate_t o_in_rate [32],
  output bprms_pkg::bprms_rate_t o_out_rate [32],
  output logic [31:0] o_stream_used,
  output logic o_selftest_mode,
  output logic o_scan_mode
);
  import bprms_pkg::*;
  logic [1:0] in_rate_q [NUM_STREAMS];
  logic [1:0] out_rate_q [NUM_STREAMS];
  logic [3:0] start_q;
  logic mode_q;
  logic [3:0] start_prev_q;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic [3:0] done_w;
  logic [3:0] pass_w;
  logic [3:0] launch_w;
  wire [13:0] in_off_w = i_req.addr - IN_RATE_BASE;
  wire [13:0] out_off_w = i_req.addr - OUT_RATE_BASE;
  wire in_hit_w = (i_req.addr >= IN_RATE_BASE) && (in_off_w < 14'(NUM_STREAMS)); // see R01
  wire out_hit_w = (i_req.addr >= OUT_RATE_BASE) && (out_off_w < 14'(NUM_STREAMS)); // see R03
  wire st_hit_w = (i_req.addr == SELFTEST_ADDR);
  wire rev_hit_w = (i_req.addr == REVISION_ADDR); // see R13
  wire [4:0] in_idx_w = in_off_w[4:0];
  wire [4:0] out_idx_w = out_off_w[4:0];
  wire st_wr_w = i_req.wr && st_hit_w;
  wire [3:0] start_wdata_w = {i_req.wdata[BIT_START_BPD], i_req.wdata[BIT_START_LD],
                              i_req.wdata[BIT_START_BPC], i_req.wdata[BIT_START_LC]}; // see R09 see R10
  wire [15:0] st_read_w = {3'h0, mode_q, start_q[3], done_w[3], pass_w[3], start_q[2], done_w[2], pass_w[2],
                           start_q[1], done_w[1], pass_w[1], start_q[0], done_w[0], pass_w[0]}; // see R11 see R12 see R15
  genvar g;
  generate
    for (g = 0; g < NUM_STREAMS; g++) begin : g_stream
      always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
          in_rate_q[g] <= RATE_RESET;
          out_rate_q[g] <= RATE_RESET;
        end else begin
          if (i_req.wr && in_hit_w && in_idx_w == 5'(g)) begin
            in_rate_q[g] <= i_req.wdata[1:0]; // see R01 see R15
          end
          if (i_req.wr && out_hit_w && out_idx_w == 5'(g)) begin
            out_rate_q[g] <= i_req.wdata[1:0]; // see R03 see R15
          end
        end
      end
      // Wide mode overrides the per-stream codes and parks the upper half.
      assign o_in_rate[g] = i_wide_mode ? (g < WIDE_STREAMS ? BPRMS_RATE_32M : BPRMS_RATE_2M)
                                        : bprms_rate_t'({1'b0, in_rate_q[g]}); // see R02 see R05
      assign o_out_rate[g] = i_wide_mode ? (g < WIDE_STREAMS ? BPRMS_RATE_32M : BPRMS_RATE_2M)
                                         : bprms_rate_t'({1'b0, out_rate_q[g]}); // see R04 see R05
      assign o_stream_used[g] = !i_wide_mode || (g < WIDE_STREAMS); // see R05
    end
    for (g = 0; g < NUM_MEMS; g++) begin : g_mem
      assign launch_w[g] = start_q[g] && !start_prev_q[g]; // see R08
      bprms_mem_test #(
        .CYCLES(TEST_LEN)
      ) u_test (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_start(launch_w[g]),
        .i_mode_en(mode_q),
        .i_fail(i_mem_fail[g]),
        .o_done(done_w[g]),
        .o_pass(pass_w[g])
      );
    end
  endgenerate
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q <= SELFTEST_RESET[BIT_MODE_EN];
      start_q <= 4'h0;
      start_prev_q <= 4'h0;
    end else begin
      start_prev_q <= start_q;
      if (st_wr_w) begin
        mode_q <= i_req.wdata[BIT_MODE_EN]; // see R07
        // Start bits are taken only while test mode was already enabled by an earlier write.
        start_q <= (mode_q && i_req.wdata[BIT_MODE_EN]) ? start_wdata_w : 4'h0; // see R06
      end
    end
  end
  always_comb begin
    rdata_d = 16'h0000;
    if (in_hit_w) begin
      rdata_d = {14'h0000, in_rate_q[in_idx_w]};
    end else if (out_hit_w) begin
      rdata_d = {14'h0000, out_rate_q[out_idx_w]};
    end else if (st_hit_w) begin
      rdata_d = st_read_w;
    end else if (rev_hit_w) begin
      rdata_d = {12'h000, REVISION}; // see R13 see R14
    end
  end
  always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rdata_q <= 16'h0000;
    end else if (i_req.rd) begin
      rdata_q <= rdata_d;
    end
  end
  assign o_rdata = rdata_q;
  assign o_selftest_mode = mode_q; // see R07
  assign o_scan_mode = !mode_q;
endmodule

// [bprms_host.sv]
// Host processor model that issues one-cycle register strobes.
`timescale 1ns/1ps
module bprms_host (
  input wire logic i_ref_clk,
  input wire bprms_pkg::bprms_req_t i_cmd,
  output bprms_pkg::bprms_req_t o_req
);
  import bprms_pkg::*;
  // Each access lasts one cycle, so enable and start writes stay separate accesses.
  always_ff @(posedge i_ref_clk) o_req <= i_cmd;
endmodule

// [bprms_regs_checker.sv]
// Port checker of the backplane rate and self-test register bank.
`timescale 1ns/1ps
module bprms_regs_checker (
  input wire logic i_ref_clk,
  input wire logic i_reset_n,
  input wire bprms_pkg::bprms_req_t i_req,
  input wire logic i_wide_mode,
  input wire logic [3:0] i_mem_fail,
  input wire logic [15:0] o_rdata,
  input wire bprms_pkg::bprms_rate_t o_in_rate [32],
  input wire bprms_pkg::bprms_rate_t o_out_rate [32],
  input wire logic [31:0] o_stream_used,
  input wire logic o_selftest_mode,
  input wire logic o_scan_mode
);
  import bprms_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_reset_n);
  a_mode_write: assert property (i_req.wr && i_req.addr == SELFTEST_ADDR |=> o_selftest_mode == $past(i_req.wdata[12]) && o_scan_mode != o_selftest_mode)
    else $error("Mode bit wrong after write.");
  a_wide_rate: assert property (i_wide_mode |-> o_in_rate[0] == BPRMS_RATE_32M && o_out_rate[15] == BPRMS_RATE_32M)
    else $error("Wide mode rate wrong.");
  a_wide_unused: assert property (i_wide_mode |-> o_stream_used == 32'h0000FFFF)
    else $error("Wide mode stream use wrong.");
  a_narrow_used: assert property (!i_wide_mode |-> o_stream_used == 32'hFFFFFFFF && !o_in_rate[31][2])
    else $error("Narrow mode stream use wrong.");
  a_in_write: assert property (i_req.wr && i_req.addr == IN_RATE_BASE ##1 !i_wide_mode |-> o_in_rate[0] == {1'b0, $past(i_req.wdata[1:0])})
    else $error("Input rate not applied.");
  a_out_write: assert property (i_req.wr && i_req.addr == OUT_RATE_BASE + 14'h001F ##1 !i_wide_mode |-> o_out_rate[31] == {1'b0, $past(i_req.wdata[1:0])})
    else $error("Output rate not applied.");
  a_rev_upper: assert property (i_req.rd && i_req.addr == REVISION_ADDR |=> o_rdata[15:4] == 12'h000)
    else $error("Revision upper bits not zero.");
  a_test_rsv: assert property (i_req.rd && i_req.addr == SELFTEST_ADDR |=> o_rdata[15:13] == 3'h0 && !(o_rdata[9] && !o_rdata[10]))
    else $error("Self-test reserved or pass bit wrong.");
endmodule
bind bprms_regs bprms_regs_checker u_bprms_regs_checker (.i_ref_clk, .i_reset_n, .i_req, .i_wide_mode, .i_mem_fail,
  .o_rdata, .o_in_rate, .o_out_rate, .o_stream_used, .o_selftest_mode, .o_scan_mode);

// [tb_top.sv]
// Self-checking testbench of the backplane rate and self-test register bank.
`timescale 1ns/1ps
module tb_top;
  import bprms_pkg::*;
  logic i_ref_clk = 1'b0;
  logic i_reset_n = 1'b0;
  logic i_wide_mode = 1'b0;
  logic [3:0] i_mem_fail = 4'h0;
  bprms_req_t cmd = '0;
  bprms_req_t req;
  logic [15:0] o_rdata;
  bprms_rate_t o_in_rate [32];
  bprms_rate_t o_out_rate [32];
  logic [31:0] o_stream_used;
  logic o_selftest_mode;
  logic o_scan_mode;
  logic [15:0] exp_q [$];
  logic rd_d = 1'b0;
  int n_fail = 0;
  int checks_done = 0;
  int s;
  logic [1:0] c;
  always #10 i_ref_clk = ~i_ref_clk;
  bprms_host u_bprms_host (.i_ref_clk, .i_cmd(cmd), .o_req(req));
  // The revision value is arbitrary.
  bprms_regs #(.REVISION(4'hA), .TEST_LEN(4)) u_bprms_regs (.i_ref_clk, .i_reset_n, .i_req(req), .i_wide_mode,
    .i_mem_fail, .o_rdata, .o_in_rate, .o_out_rate, .o_stream_used, .o_selftest_mode, .o_scan_mode);
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // A read notes its expected data; a write carries the data written.
  task automatic acc(input logic wr, input logic [13:0] a, input logic [15:0] d);
    if (!wr) exp_q.push_back(d);
    @(posedge i_ref_clk);
    cmd <= '{wr, !wr, a, d};
    @(posedge i_ref_clk);
    cmd <= '0;
  endtask
  task automatic drain(input string t);
    for (int i = 0; i < 50 && exp_q.size() > 0; i++) @(posedge i_ref_clk);
    if (exp_q.size() > 0) begin
      n_fail++;
      $display("ERROR %0t: read data missing in test %s", $time, t);
      test_done();
    end else begin
      $display("Test %s done", t);
    end
  endtask
  // Read data is valid the cycle after the read strobe.
  always @(posedge i_ref_clk) begin
    if (rd_d) check(o_rdata, exp_q.pop_front());
    rd_d = req.rd;
  end
  initial begin
    void'($urandom(96));
    repeat (8) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    acc(0, REVISION_ADDR, 16'h000A);
    acc(1, REVISION_ADDR, 16'hFFF5);
    acc(0, REVISION_ADDR, 16'h000A);
    acc(0, 14'h0100, 16'h0000);
    drain("revision");
    for (int k = 0; k < 8; k++) begin
      s = $urandom_range(31);
      c = k[1:0];
      acc(1, IN_RATE_BASE + 14'(s), {14'($urandom), c});
      acc(1, OUT_RATE_BASE + 14'(s), {14'($urandom), ~c});
      acc(0, IN_RATE_BASE + 14'(s), {14'h0, c});
      acc(0, OUT_RATE_BASE + 14'(s), {14'h0, ~c});
      check({13'h0, o_in_rate[s]}, {14'h0, c});
      check({13'h0, o_out_rate[s]}, {14'h0, ~c});
    end
    acc(1, IN_RATE_BASE, 16'h0003);
    acc(1, OUT_RATE_BASE + 14'h001F, 16'h0002);
    repeat (2) @(posedge i_ref_clk);
    i_wide_mode <= 1'b1;
    @(negedge i_ref_clk);
    check({13'h0, o_in_rate[3]}, {13'h0, BPRMS_RATE_32M});
    check({13'h0, o_out_rate[0]}, {13'h0, BPRMS_RATE_32M});
    check({13'h0, o_in_rate[20]}, {13'h0, BPRMS_RATE_2M});
    check(o_stream_used[31:16], 16'h0000);
    @(posedge i_ref_clk);
    i_wide_mode <= 1'b0;
    @(negedge i_ref_clk);
    check({13'h0, o_in_rate[0]}, 16'h0003);
    check({13'h0, o_out_rate[31]}, 16'h0002);
    @(posedge i_ref_clk);
    drain("rates");
    i_mem_fail <= 4'h5;
    acc(1, SELFTEST_ADDR, 16'h0800);
    acc(0, SELFTEST_ADDR, 16'h0000);
    acc(1, SELFTEST_ADDR, SELFTEST_ENABLE_VALUE);
    acc(1, SELFTEST_ADDR, 16'hFFFF);
    repeat (12) @(posedge i_ref_clk);
    acc(0, SELFTEST_ADDR, 16'h1FBE);
    acc(1, SELFTEST_ADDR, 16'hFFFF);
    acc(0, SELFTEST_ADDR, 16'h1FBE);
    check({14'h0, o_selftest_mode, o_scan_mode}, 16'h0002);
    i_mem_fail <= 4'hA;
    acc(1, SELFTEST_ADDR, SELFTEST_ENABLE_VALUE);
    acc(1, SELFTEST_ADDR, 16'h1800);
    acc(0, SELFTEST_ADDR, 16'h189A);
    repeat (12) @(posedge i_ref_clk);
    acc(0, SELFTEST_ADDR, 16'h1C9A);
    acc(1, SELFTEST_ADDR, 16'h0000);
    acc(0, SELFTEST_ADDR, 16'h0000);
    check({14'h0, o_selftest_mode, o_scan_mode}, 16'h0001);
    drain("selftest");
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    i_reset_n <= 1'b1;
    @(negedge i_ref_clk);
    check({13'h0, o_in_rate[0]}, {13'h0, BPRMS_RATE_2M});
    check({14'h0, o_selftest_mode, o_scan_mode}, 16'h0001);
    acc(0, OUT_RATE_BASE + 14'h001F, 16'h0000);
    drain("reset");
    test_done();
  end
endmodule
